// ---- cache_ctrl_defines.svh ----
// Offsets, field positions, reset values and address windows of the cache control block.
`ifndef CACHE_CTRL_DEFINES_SVH
`define CACHE_CTRL_DEFINES_SVH

// -----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// -----------------------------------------------------------------------------
`define CC_CTRL_IDX 10'h0E2
`define CC_STAT_IDX 10'h0E3

// -----------------------------------------------------------------------------
// Control and status fields.
// -----------------------------------------------------------------------------
`define CC_CTRL_L1_BIT 7
`define CC_CTRL_L2FL_BIT 6
`define CC_CTRL_L2EN_BIT 5
`define CC_CTRL_RSV_MSB 4
`define CC_CTRL_RESET 8'h00
`define CC_STAT_TYPE_BIT 6
`define CC_STAT_L2P_HI 5
`define CC_STAT_L2P_LO 4
`define CC_STAT_L2PE_BIT 3
`define CC_STAT_PEA_BIT 1
`define CC_STAT_PEB_BIT 0
`define CC_PARITY_RESET 3'h7

// -----------------------------------------------------------------------------
// ROM windows.
// -----------------------------------------------------------------------------
`define CC_ROM_LOW_BASE 32'h000E0000
`define CC_ROM_LOW_LAST 32'h000FFFFF
`define CC_ROM_HIGH_BASE 32'hFFFE0000
`define CC_ROM_HIGH_LAST 32'hFFFFFFFF
`define CC_ROM_PAGE_MASK 32'hFFFFF000

`endif

// ---- cache_ctrl_pkg.sv ----
// Types shared by the cache control block and its bench.
package cache_ctrl_pkg;

  typedef struct packed {
    logic l1Enable;
    logic l1Flush;
    logic l2Flush;
    logic l2Enable;
  } cache_ctl_t;

  typedef struct packed {
    logic type2Fitted;
    logic l2Fitted;
    logic l2ParityEvent;
    logic bankAParityEvent;
    logic bankBParityEvent;
    logic parityClear;
  } status_in_t;

  typedef struct packed {
    logic [31:0] addr;
    logic boardMem;
    logic romEnable;
    logic romDecodeDisable;
  } mem_req_t;

  typedef struct packed {
    logic romSelect;
    logic ramSelect;
    logic cacheable;
  } mem_dec_t;

endpackage

// ---- cache_ctrl_status_rom_decode.sv ----
// Cache control and status registers with boot ROM window decode, APB slave.
`include "cache_ctrl_defines.svh"

module cache_ctrl_status_rom_decode #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Cache controls and board status.
  output cache_ctrl_pkg::cache_ctl_t cacheCtl,
  input wire cache_ctrl_pkg::status_in_t statusIn,
  // Memory decode.
  input wire cache_ctrl_pkg::mem_req_t memReq,
  output cache_ctrl_pkg::mem_dec_t memDec
);

  // ---------------------------------------------------------------------------
  // Address decode.
  // ---------------------------------------------------------------------------
  function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    regHit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic inWindow(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    inWindow = (a >= lo) && (a <= hi);
  endfunction

  logic [7:0] ctrl;
  logic [2:0] parityN;
  logic hitCtrl;
  logic hitStat;
  logic setup;
  logic access;
  logic ctrlWrite;
  logic [7:0] statusByte;
  logic l1FlushQ;

  assign setup = ce && psel && !penable;
  assign access = ce && psel && penable;

  always_comb begin
    hitCtrl = 1'b0;
    hitStat = 1'b0;
    if (regHit(paddr, `CC_CTRL_IDX)) begin
      hitCtrl = 1'b1;
    end else if (regHit(paddr, `CC_STAT_IDX)) begin
      hitStat = 1'b1;
    end
  end

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = access;
  assign pslverr = access && !hitCtrl && !hitStat;
  assign ctrlWrite = access && pwrite && hitCtrl && pstrb[0];

  // ---------------------------------------------------------------------------
  // Cache control register.
  // ---------------------------------------------------------------------------
  // Reserved bits are stored so software reads back what it wrote.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= `CC_CTRL_RESET;
    end else if (ctrlWrite) begin
      ctrl <= pwdata[7:0];
    end
  end

  // The level 1 flush strobe comes from the write itself, so a write that
  // leaves bit 7 at zero does not flush again.
  always_ff @(posedge mclk) begin
    if (rst) begin
      l1FlushQ <= 1'b0;
    end else if (ce) begin
      l1FlushQ <= ctrlWrite && ctrl[`CC_CTRL_L1_BIT] && !pwdata[`CC_CTRL_L1_BIT];
    end
  end

  // Only bits 7..5 reach the cache controls; bits 4..0 are only read back.
  always_comb begin
    cacheCtl.l1Enable = ctrl[`CC_CTRL_L1_BIT];
    cacheCtl.l1Flush = l1FlushQ;
    cacheCtl.l2Flush = !ctrl[`CC_CTRL_L2FL_BIT];
    cacheCtl.l2Enable = ctrl[`CC_CTRL_L2FL_BIT] && !ctrl[`CC_CTRL_L2EN_BIT];
  end

  // ---------------------------------------------------------------------------
  // Parity latches, active low.
  // ---------------------------------------------------------------------------
  // An error arriving with the clear wins, so no error is lost to a clear; events are ignored while ce is low.
  always_ff @(posedge mclk) begin
    if (rst) begin
      parityN <= `CC_PARITY_RESET;
    end else if (ce) begin
      if (statusIn.l2ParityEvent) begin
        parityN[2] <= 1'b0;
      end else if (statusIn.parityClear) begin
        parityN[2] <= 1'b1;
      end
      if (statusIn.bankAParityEvent) begin
        parityN[1] <= 1'b0;
      end else if (statusIn.parityClear) begin
        parityN[1] <= 1'b1;
      end
      if (statusIn.bankBParityEvent) begin
        parityN[0] <= 1'b0;
      end else if (statusIn.parityClear) begin
        parityN[0] <= 1'b1;
      end
    end
  end

  always_comb begin
    statusByte = 8'h00;
    statusByte[`CC_STAT_TYPE_BIT] = statusIn.type2Fitted;
    statusByte[`CC_STAT_L2P_HI] = !statusIn.l2Fitted;
    statusByte[`CC_STAT_L2P_LO] = !statusIn.l2Fitted;
    statusByte[`CC_STAT_L2PE_BIT] = parityN[2];
    statusByte[`CC_STAT_PEA_BIT] = parityN[1];
    statusByte[`CC_STAT_PEB_BIT] = parityN[0];
  end

  // ---------------------------------------------------------------------------
  // Read data, captured in the setup cycle.
  // ---------------------------------------------------------------------------
  // Writes to the status location are accepted and dropped.
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      if (hitCtrl) begin
        prdata <= {24'h000000, ctrl};
      end else if (hitStat) begin
        prdata <= {24'h000000, statusByte};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // ROM window decode, registered.
  // ---------------------------------------------------------------------------
  logic lowWin;
  logic highWin;
  logic firstPage;
  logic romHit;

  // The first 4KB of each window can be handed back to the system decode.
  always_comb begin
    lowWin = inWindow(memReq.addr, `CC_ROM_LOW_BASE, `CC_ROM_LOW_LAST);
    highWin = inWindow(memReq.addr, `CC_ROM_HIGH_BASE, `CC_ROM_HIGH_LAST);
    firstPage = ((memReq.addr & `CC_ROM_PAGE_MASK) == `CC_ROM_LOW_BASE) ||
                ((memReq.addr & `CC_ROM_PAGE_MASK) == `CC_ROM_HIGH_BASE);
    romHit = ((lowWin && memReq.romEnable) || highWin) &&
             !(firstPage && memReq.romDecodeDisable);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      memDec <= '0;
    end else if (ce) begin
      memDec.romSelect <= romHit;
      memDec.ramSelect <= !romHit && memReq.boardMem;
      memDec.cacheable <= !romHit && memReq.boardMem;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_l1FlushPulse;
    ctrlWrite && ctrl[7] && !pwdata[7] |=> cacheCtl.l1Flush && !cacheCtl.l1Enable ##1 (!cacheCtl.l1Flush || !$past(ce));
  endproperty
  a_l1FlushPulse: assert property (p_l1FlushPulse) else $error("level 1 flush not one cycle");

  property p_l1NoFlushFromZero;
    ctrlWrite && !ctrl[7] |=> !cacheCtl.l1Flush;
  endproperty
  a_l1NoFlushFromZero: assert property (p_l1NoFlushFromZero) else $error("spurious level 1 flush");

  property p_l1Enable;
    ctrlWrite && pwdata[7] |=> cacheCtl.l1Enable && !cacheCtl.l1Flush;
  endproperty
  a_l1Enable: assert property (p_l1Enable) else $error("level 1 not enabled");

  property p_l2Held;
    ctrlWrite && !pwdata[6] |=> cacheCtl.l2Flush && !cacheCtl.l2Enable;
  endproperty
  a_l2Held: assert property (p_l2Held) else $error("level 2 not held flushed");

  property p_l2Enable;
    ctrlWrite && pwdata[6] && !pwdata[5] |=> cacheCtl.l2Enable && !cacheCtl.l2Flush;
  endproperty
  a_l2Enable: assert property (p_l2Enable) else $error("level 2 not enabled");

  property p_l2Bypass;
    ctrlWrite && pwdata[6] && pwdata[5] |=> !cacheCtl.l2Enable && !cacheCtl.l2Flush;
  endproperty
  a_l2Bypass: assert property (p_l2Bypass) else $error("level 2 not bypassed");

  property p_reservedInert;
    ctrlWrite && (pwdata[7:5] == ctrl[7:5]) |=> $stable({cacheCtl.l1Enable, cacheCtl.l2Flush, cacheCtl.l2Enable});
  endproperty
  a_reservedInert: assert property (p_reservedInert) else $error("reserved bits changed cache state");

  property p_ctrlReadback;
    setup && hitCtrl |=> prdata == {24'h000000, ctrl};
  endproperty
  a_ctrlReadback: assert property (p_ctrlReadback) else $error("control readback wrong");

  property p_statusReadOnly;
    access && pwrite && hitStat && !statusIn.parityClear && !statusIn.l2ParityEvent &&
      !statusIn.bankAParityEvent && !statusIn.bankBParityEvent |=> $stable(ctrl) && $stable(parityN);
  endproperty
  a_statusReadOnly: assert property (p_statusReadOnly) else $error("status write had effect");

  property p_parityA;
    !parityN[1] && !(ce && statusIn.parityClear) |=> !parityN[1];
  endproperty
  a_parityA: assert property (p_parityA) else $error("bank A parity lost before clear");

  property p_parityAset;
    ce && statusIn.bankAParityEvent |=> !parityN[1];
  endproperty
  a_parityAset: assert property (p_parityAset) else $error("bank A parity not latched");

  property p_l2ParityClear;
    ce && statusIn.parityClear && !statusIn.l2ParityEvent |=> parityN[2];
  endproperty
  a_l2ParityClear: assert property (p_l2ParityClear) else $error("level 2 parity not cleared");

  property p_romHigh;
    ce && highWin && !firstPage |=> memDec.romSelect && !memDec.cacheable;
  endproperty
  a_romHigh: assert property (p_romHigh) else $error("top ROM window missed");

  property p_uncachedOffBoard;
    ce && !memReq.boardMem |=> !memDec.cacheable;
  endproperty
  a_uncachedOffBoard: assert property (p_uncachedOffBoard) else $error("off-board memory cached");

  property p_lowRam;
    ce && lowWin && !memReq.romEnable && memReq.boardMem |=> memDec.ramSelect && !memDec.romSelect;
  endproperty
  a_lowRam: assert property (p_lowRam) else $error("low window not routed to RAM");

  property p_resetState;
    disable iff (1'b0) rst |=> ctrl == `CC_CTRL_RESET && parityN == `CC_PARITY_RESET && !l1FlushQ && memDec == '0;
  endproperty
  a_resetState: assert property (p_resetState) else $error("reset state wrong");

  property p_errUnmapped;
    access && paddr != ADDR_W'({`CC_CTRL_IDX, 2'b00}) && paddr != ADDR_W'({`CC_STAT_IDX, 2'b00}) |-> pslverr;
  endproperty
  a_errUnmapped: assert property (p_errUnmapped) else $error("unmapped access without error");

  property p_noErrMapped;
    access && (hitCtrl || hitStat) |-> pready && !pslverr;
  endproperty
  a_noErrMapped: assert property (p_noErrMapped) else $error("mapped access flagged");

  property p_ctrlWriteLands;
    ctrlWrite |=> ctrl == $past(pwdata[7:0]);
  endproperty
  a_ctrlWriteLands: assert property (p_ctrlWriteLands) else $error("control write lost");

  property p_ctrlHold;
    !ctrlWrite |=> $stable(ctrl);
  endproperty
  a_ctrlHold: assert property (p_ctrlHold) else $error("control changed without write");

  property p_strbMasked;
    access && pwrite && hitCtrl && !pstrb[0] |=> $stable(ctrl);
  endproperty
  a_strbMasked: assert property (p_strbMasked) else $error("masked control write landed");

  property p_statReadback;
    setup && hitStat |=> prdata == {24'h000000, $past(statusByte)};
  endproperty
  a_statReadback: assert property (p_statReadback) else $error("status readback wrong");

  property p_statusReserved;
    !statusByte[7] && !statusByte[2];
  endproperty
  a_statusReserved: assert property (p_statusReserved) else $error("reserved status bit set");

  property p_typeBit;
    statusByte[6] == statusIn.type2Fitted;
  endproperty
  a_typeBit: assert property (p_typeBit) else $error("processor type bit wrong");

  property p_l2Fitted;
    statusByte[5:4] == {2{!statusIn.l2Fitted}};
  endproperty
  a_l2Fitted: assert property (p_l2Fitted) else $error("level 2 presence bits wrong");

  property p_l2ParitySet;
    ce && statusIn.l2ParityEvent |=> !parityN[2];
  endproperty
  a_l2ParitySet: assert property (p_l2ParitySet) else $error("level 2 parity not latched");

  property p_parityBset;
    ce && statusIn.bankBParityEvent |=> !parityN[0];
  endproperty
  a_parityBset: assert property (p_parityBset) else $error("bank B parity not latched");

  property p_parityBclear;
    ce && statusIn.parityClear && !statusIn.bankBParityEvent |=> parityN[0];
  endproperty
  a_parityBclear: assert property (p_parityBclear) else $error("bank B parity not cleared");

  property p_parityAclear;
    ce && statusIn.parityClear && !statusIn.bankAParityEvent |=> parityN[1];
  endproperty
  a_parityAclear: assert property (p_parityAclear) else $error("bank A parity not cleared");

  property p_parityFrozen;
    !ce |=> $stable(parityN);
  endproperty
  a_parityFrozen: assert property (p_parityFrozen) else $error("parity moved while disabled");

  property p_ctrlFrozen;
    !ce |=> $stable(ctrl) && $stable(memDec);
  endproperty
  a_ctrlFrozen: assert property (p_ctrlFrozen) else $error("state moved while disabled");

  property p_flushSource;
    $rose(cacheCtl.l1Flush) |-> $past(ctrlWrite) && $past(ctrl[7]);
  endproperty
  a_flushSource: assert property (p_flushSource) else $error("level 1 flush without write");

  property p_romLow;
    ce && lowWin && memReq.romEnable && !(firstPage && memReq.romDecodeDisable) |=>
      memDec.romSelect && !memDec.ramSelect;
  endproperty
  a_romLow: assert property (p_romLow) else $error("low ROM window missed");

  property p_romUncached;
    memDec.romSelect |-> !memDec.cacheable && !memDec.ramSelect;
  endproperty
  a_romUncached: assert property (p_romUncached) else $error("ROM marked cacheable");

  property p_firstPage;
    ce && firstPage && memReq.romDecodeDisable |=> !memDec.romSelect && memDec.cacheable == $past(memReq.boardMem);
  endproperty
  a_firstPage: assert property (p_firstPage) else $error("first ROM page not handed back");

  property p_outsideWindows;
    ce && !lowWin && !highWin |=> !memDec.romSelect;
  endproperty
  a_outsideWindows: assert property (p_outsideWindows) else $error("ROM selected outside windows");

  property p_l2Exclusive;
    !(cacheCtl.l2Flush && cacheCtl.l2Enable);
  endproperty
  a_l2Exclusive: assert property (p_l2Exclusive) else $error("level 2 flushed and enabled");

  c_l1Flush: cover property (ctrlWrite && ctrl[7] && !pwdata[7] ##1 cacheCtl.l1Flush);
  c_l2Enable: cover property (ctrlWrite && pwdata[6] && !pwdata[5]);
  c_parityRace: cover property (ce && statusIn.bankBParityEvent && statusIn.parityClear);
  c_romLow: cover property (ce && lowWin && memReq.romEnable);
  c_l2Bypass: cover property (ctrlWrite && pwdata[6] && pwdata[5]);

endmodule

// ---- cache_ctrl_status_rom_decode_bench.sv ----
// Self-checking bench for the cache control, status and ROM decode block.
`include "cache_ctrl_defines.svh"

module cache_ctrl_status_rom_decode_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] CTRL_A = {`CC_CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT_A = {`CC_STAT_IDX, 2'b00};
  localparam logic [7:0] CORNER [8] = '{8'h80, 8'h00, 8'hC0, 8'h40, 8'hE0, 8'h7F, 8'hFF, 8'h1F};
  localparam logic [31:0] ADDRS [10] = '{32'h000E0000, 32'h000E0FFF, 32'h000E1000, 32'h000FFFFF,
    32'h00100000, 32'hFFFE0000, 32'hFFFE0FFF, 32'hFFFF0000, 32'h000DFFFF, 32'hFFFDFFFF};
  // Clock, reset, enable.
  logic mclk;
  logic rst;
  logic ce;
  // APB.
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  // Cache controls, status and decode.
  cache_ctrl_pkg::cache_ctl_t cacheCtl;
  cache_ctrl_pkg::status_in_t statusIn;
  cache_ctrl_pkg::mem_req_t memReq;
  cache_ctrl_pkg::mem_dec_t memDec;
  int errors, tests_run, seed;
  logic err;
  logic [7:0] ctl, nxt;
  logic [2:0] lat, ev;

  cache_ctrl_status_rom_decode #(.ADDR_W(12)) u_dut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cacheCtl(cacheCtl), .statusIn(statusIn), .memReq(memReq),
    .memDec(memDec));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------------------
  // Checking and closing.
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Expected cache controls; reserved bits 4-0 deliberately play no part.
  function automatic logic [3:0] exp_ctl(input logic [7:0] c, input logic fl);
    return {c[7], fl, ~c[6], c[6] & ~c[5]};
  endfunction

  function automatic logic [2:0] exp_dec(input cache_ctrl_pkg::mem_req_t r);
    logic low, high, page, hit;
    low = r.addr >= 32'h000E0000 && r.addr <= 32'h000FFFFF;
    high = r.addr >= 32'hFFFE0000;
    page = (r.addr & 32'hFFFFF000) == 32'h000E0000 || (r.addr & 32'hFFFFF000) == 32'hFFFE0000;
    hit = ((low & r.romEnable) | high) & ~(r.romDecodeDisable & page);
    return {hit, ~hit & r.boardMem, ~hit & r.boardMem};
  endfunction

  // ---------------------------------------------------------------------------
  // APB master: waits for pready under a bound, takes data at that edge.
  // ---------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_ctl(input logic [7:0] v, input logic [3:0] s);
    logic fl;
    apb(1'b1, CTRL_A, {$random(seed)} & 32'hFFFFFF00 | {24'h0, v}, s);
    fl = s[0] & ctl[7] & ~v[7];
    if (s[0]) begin
      ctl = v;
    end
    #1 check("cacheCtl", {28'h0, cacheCtl}, {28'h0, exp_ctl(ctl, fl)});
    @(posedge mclk);
    #1 check("l1Flush width", {31'h0, cacheCtl.l1Flush}, 32'h0);
    apb(1'b0, CTRL_A, 32'h0, 4'h0);
    check("control readback", rd, {24'h0, ctl});
  endtask

  task automatic rd_stat();
    apb(1'b0, STAT_A, 32'h0, 4'h0);
    check("status", rd, {24'h0, 1'b0, statusIn.type2Fitted, {2{~statusIn.l2Fitted}}, lat[2], 1'b0,
      lat[1:0]});
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    errors = 0;
    tests_run = 0;
    seed = 32'h05c4;
    rst = 1'b1;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    statusIn = '0;
    memReq = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    #1 check("cacheCtl reset", {28'h0, cacheCtl}, 32'h2);
    ctl = 8'h00;
    for (int i = 0; i < 24; i++) begin
      nxt = (i < 8) ? CORNER[i] : 8'($random(seed));
      wr_ctl(nxt, 4'h1);
    end
    wr_ctl(~ctl, 4'h0);
    // Parity latches hold until cleared, so events are fired and then read.
    lat = 3'h7;
    for (int i = 0; i < 8; i++) begin
      ev = 3'($random(seed));
      @(posedge mclk);
      statusIn.type2Fitted <= 1'($random(seed));
      statusIn.l2Fitted <= 1'($random(seed));
      {statusIn.l2ParityEvent, statusIn.bankAParityEvent, statusIn.bankBParityEvent} <= ev;
      @(posedge mclk);
      {statusIn.l2ParityEvent, statusIn.bankAParityEvent, statusIn.bankBParityEvent} <= 3'h0;
      lat = lat & ~ev;
      rd_stat();
      apb(1'b1, STAT_A, 32'hFFFFFFFF, 4'hF);
      check("status write err", {31'h0, err}, 32'h0);
      rd_stat();
      if (i[0]) begin
        @(posedge mclk);
        statusIn.parityClear <= 1'b1;
        @(posedge mclk);
        statusIn.parityClear <= 1'b0;
        lat = 3'h7;
        rd_stat();
      end
    end
    // A low enable freezes latches and decode; an event seen only then is dropped.
    @(posedge mclk);
    ce <= 1'b0;
    statusIn.bankAParityEvent <= 1'b1;
    memReq.addr <= 32'hFFFF0000;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    statusIn.bankAParityEvent <= 1'b0;
    memReq.addr <= 32'h00000000;
    #1 check("frozen decode", {29'h0, memDec}, {29'h0, exp_dec('0)});
    rd_stat();
    // An error in the same cycle as the clear must survive it.
    @(posedge mclk);
    statusIn.bankBParityEvent <= 1'b1;
    statusIn.parityClear <= 1'b1;
    @(posedge mclk);
    statusIn.bankBParityEvent <= 1'b0;
    statusIn.parityClear <= 1'b0;
    lat = 3'h6;
    rd_stat();
    apb(1'b1, 12'h390, 32'hFF, 4'hF);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check("unmapped read", {err, rd[30:0]}, 32'h80000000);
    apb(1'b0, CTRL_A, 32'h0, 4'h0);
    check("control kept", rd, {24'h0, ctl});
    wr_ctl(8'h00, 4'h1);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      memReq.addr <= (i < 20) ? ADDRS[i % 10] : 32'($random(seed));
      {memReq.boardMem, memReq.romEnable, memReq.romDecodeDisable} <= (i < 20) ? i[2:0] : 3'($random(seed));
      @(posedge mclk);
      #1 check("memDec", {29'h0, memDec}, {29'h0, exp_dec(memReq)});
    end
    test_done();
  end
endmodule
